// [emc_pkg.sv]
// constants, types and code table shared by the mode control and checkbit logic
package emc_pkg;

  // ==========================================================================
  // widths
  localparam int EMC_DATA_W  = 64;
  localparam int EMC_CB_W    = 8;
  localparam int EMC_BYTES   = 8;
  localparam int EMC_MODE_W  = 16;
  localparam int EMC_COLUMNS = 64;

  // ==========================================================================
  // values after reset and fixed codes
  localparam logic [15:0] EMC_MODE_RESET     = 16'h0003;
  localparam logic [15:0] EMC_MODE_USED_MASK = 16'h007F;
  localparam logic [7:0]  EMC_ZERO_CHECKBITS = 8'h0C;
  localparam logic [3:0]  EMC_COUNT_MAX      = 4'hF;
  localparam logic [3:0]  EMC_COUNT_ONE      = 4'h1;
  localparam logic [4:0]  EMC_FIFO_DEPTH_DUAL   = 5'h08;
  localparam logic [4:0]  EMC_FIFO_DEPTH_SINGLE = 5'h10;
  localparam int          EMC_DIAG_W         = 38;

  // ==========================================================================
  // operating modes
  typedef enum logic [2:0] {
    EMC_MODE_ERROR_DATA = 3'h0,
    EMC_MODE_DIAG_OUT   = 3'h1,
    EMC_MODE_DETECT     = 3'h2,
    EMC_MODE_NORMAL     = 3'h3,
    EMC_MODE_INJECT     = 3'h4
  } emc_op_mode_t;

  // mode register layout, bit 15 down to bit 0
  typedef struct packed {
    logic [8:0]   unused;
    logic         readback;
    logic         parity_odd;
    logic         fifo_single;
    logic         clear;
    emc_op_mode_t mode;
  } emc_mode_reg_t;

  // diagnostic output word, bit 37 down to bit 0
  typedef struct packed {
    logic [7:0] syndrome_every;
    logic       multi;
    logic       err;
    logic [3:0] count;
    logic [7:0] syndrome_first;
    logic [7:0] checkbit_first;
    logic [7:0] checkbit_latch;
  } emc_diag_t;

  // ==========================================================================
  // code column for data bit idx: weight-3 codes first, then weight-5
  function automatic logic [7:0] emc_column(input int idx);
    int         n;
    logic [7:0] c;
    logic [7:0] v8;
    n = 0;
    c = 8'h00;
    v8 = 8'h00;
    for (int v = 0; v < 256; v++) begin
      v8 = v[7:0];
      if ($countones(v8) == 3) begin
        if (n == idx) c = v8;
        n = n + 1;
      end
    end
    for (int v = 0; v < 256; v++) begin
      v8 = v[7:0];
      if ($countones(v8) == 5) begin
        if (n == idx) c = v8;
        n = n + 1;
      end
    end
    return c;
  endfunction : emc_column

endpackage : emc_pkg

// [emc_checkbit_gen.sv]
// checkbit generator for one 64-bit data word
`timescale 1ns/10ps
module emc_checkbit_gen (
  input  wire logic [63:0] data_word,
  output logic      [7:0]  checkbits
);

  // ==========================================================================
  // parity tree, seeded so that all-zero data gives the fixed code
  always_comb begin
    checkbits = emc_pkg::EMC_ZERO_CHECKBITS;
    for (int j = 0; j < emc_pkg::EMC_COLUMNS; j++) begin
      if (data_word[j]) checkbits = checkbits ^ emc_pkg::emc_column(j);
    end
  end

endmodule : emc_checkbit_gen

// [emc_mode_control.sv]
// mode register, read decode, diagnostics and write path of the edc unit
`timescale 1ns/10ps
module emc_mode_control (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        mode_write_enable_n,
  input  wire logic [63:0] system_data_in,
  output logic      [63:0] system_data_out,
  output logic      [7:0]  system_data_oe,
  input  wire logic        system_output_enable_n,
  input  wire logic        system_input_latch_enable,
  input  wire logic [7:0]  byte_lane_enables,
  input  wire logic        write_buffer_select,
  input  wire logic [7:0]  parity_in,
  output logic      [7:0]  parity_out,
  output logic             parity_error_n,
  input  wire logic [63:0] memory_data_in,
  input  wire logic [7:0]  checkbit_input,
  input  wire logic        memory_read_strobe,
  input  wire logic        memory_write_strobe,
  output logic      [63:0] memory_data_out,
  output logic      [7:0]  checkbit_output,
  output logic             error_flag_n,
  output logic             multi_error_flag_n,
  output logic             fifo_depth_select,
  output logic      [4:0]  fifo_depth,
  output logic      [2:0]  edc_mode_field
);

  // ==========================================================================
  // declarations
  emc_pkg::emc_mode_reg_t mode_reg;
  emc_pkg::emc_diag_t     diag_word;
  logic                   clear_strobe;
  logic [63:0]            sd_latch;
  logic [7:0]             inject_latch;
  logic [63:0]            md_latch;
  logic [7:0]             cbi_latch;
  logic                   read_done;
  logic [7:0]             read_gen_cb;
  logic [7:0]             recv_cb;
  logic [7:0]             syndrome;
  logic [63:0]            flip;
  logic                   syn_nonzero;
  logic                   syn_odd;
  logic                   single_err;
  logic                   multi_err;
  logic [63:0]            corrected;
  logic [63:0]            read_word;
  logic                   first_seen;
  logic                   first_now;
  logic [63:0]            error_data;
  logic [7:0]             checkbit_first;
  logic [7:0]             syndrome_first;
  logic                   type_err;
  logic                   type_multi;
  logic [7:0]             syndrome_every;
  logic [3:0]             error_count;
  logic [63:0]            next_system_data;
  logic [7:0]             next_parity;
  logic                   wrap_path;
  logic [63:0]            merged_word;
  logic [7:0]             write_gen_cb;
  logic [7:0]             write_parity;

  // ==========================================================================
  // mode register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg <= emc_pkg::emc_mode_reg_t'(emc_pkg::EMC_MODE_RESET);
    end else if (!mode_write_enable_n) begin
      mode_reg <= emc_pkg::emc_mode_reg_t'(system_data_in[15:0] & emc_pkg::EMC_MODE_USED_MASK);
    end
  end

  // clear acts on the write that carries the bit, so a held bit cannot mask later errors
  assign clear_strobe = !mode_write_enable_n && system_data_in[3];

  assign edc_mode_field    = mode_reg.mode;
  assign fifo_depth_select = mode_reg.fifo_single;
  assign fifo_depth        = mode_reg.fifo_single ? emc_pkg::EMC_FIFO_DEPTH_SINGLE
                                                  : emc_pkg::EMC_FIFO_DEPTH_DUAL;

  // ==========================================================================
  // system-side input latch and injected checkbit latch
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sd_latch <= '0;
    end else if (system_input_latch_enable) begin
      sd_latch <= system_data_in;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      inject_latch <= emc_pkg::EMC_ZERO_CHECKBITS;
    end else if (system_input_latch_enable && mode_reg.mode == emc_pkg::EMC_MODE_INJECT) begin
      inject_latch <= system_data_in[7:0];
    end
  end

  // ==========================================================================
  // memory read capture
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      md_latch  <= '0;
      cbi_latch <= '0;
    end else if (memory_read_strobe) begin
      md_latch  <= memory_data_in;
      cbi_latch <= checkbit_input;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      read_done <= 1'b0;
    end else begin
      read_done <= memory_read_strobe;
    end
  end

  // ==========================================================================
  // syndrome decode
  emc_checkbit_gen u_read_gen (
    .data_word (md_latch),
    .checkbits (read_gen_cb)
  );

  // injected checkbits stand in for the memory ones during mode 4 reads
  assign recv_cb = (mode_reg.mode == emc_pkg::EMC_MODE_INJECT) ? inject_latch : cbi_latch;
  assign syndrome    = read_gen_cb ^ recv_cb;
  assign syn_nonzero = |syndrome;
  assign syn_odd     = ^syndrome;

  for (genvar j = 0; j < emc_pkg::EMC_COLUMNS; j++) begin : g_flip
    assign flip[j] = (syndrome == emc_pkg::emc_column(j));
  end

  // odd weight without a matching column is uncorrectable; weight one is a checkbit error
  assign single_err = syn_nonzero && syn_odd && (|flip || $countones(syndrome) == 1);
  assign multi_err  = syn_nonzero && !single_err;
  assign corrected  = md_latch ^ flip;

  // ==========================================================================
  // read result and error flags
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      read_word <= '0;
    end else if (read_done) begin
      if (mode_reg.mode == emc_pkg::EMC_MODE_DETECT) begin
        read_word <= md_latch;
      end else begin
        read_word <= corrected;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      error_flag_n       <= 1'b1;
      multi_error_flag_n <= 1'b1;
    end else if (read_done) begin
      error_flag_n       <= !syn_nonzero;
      multi_error_flag_n <= !multi_err;
    end
  end

  // ==========================================================================
  // diagnostic registers; a capture in the clear cycle wins and counts as first
  assign first_now = !first_seen || clear_strobe;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      first_seen     <= 1'b0;
      error_data     <= '0;
      checkbit_first <= '0;
      syndrome_first <= '0;
      type_err       <= 1'b0;
      type_multi     <= 1'b0;
    end else if (read_done && syn_nonzero && first_now) begin
      first_seen     <= 1'b1;
      error_data     <= md_latch;
      checkbit_first <= recv_cb;
      syndrome_first <= syndrome;
      type_err       <= 1'b1;
      type_multi     <= multi_err;
    end else if (clear_strobe) begin
      first_seen     <= 1'b0;
      error_data     <= '0;
      checkbit_first <= '0;
      syndrome_first <= '0;
      type_err       <= 1'b0;
      type_multi     <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      syndrome_every <= '0;
      error_count    <= '0;
    end else if (read_done && syn_nonzero) begin
      syndrome_every <= syndrome;
      if (clear_strobe) begin
        error_count <= emc_pkg::EMC_COUNT_ONE;
      end else if (error_count != emc_pkg::EMC_COUNT_MAX) begin
        error_count <= error_count + emc_pkg::EMC_COUNT_ONE;
      end
    end else if (clear_strobe) begin
      syndrome_every <= '0;
      error_count    <= '0;
    end
  end

  assign diag_word = '{syndrome_every: syndrome_every,
                       multi:          type_multi,
                       err:            type_err,
                       count:          error_count,
                       syndrome_first: syndrome_first,
                       checkbit_first: checkbit_first,
                       checkbit_latch: cbi_latch};

  // ==========================================================================
  // system bus output selection; readback overrides the mode
  always_comb begin
    next_system_data = '0;
    if (mode_reg.readback) begin
      next_system_data[15:0] = mode_reg;
    end else begin
      unique case (mode_reg.mode)
        emc_pkg::EMC_MODE_ERROR_DATA: next_system_data = error_data;
        emc_pkg::EMC_MODE_DIAG_OUT:   next_system_data[emc_pkg::EMC_DIAG_W-1:0] = diag_word;
        emc_pkg::EMC_MODE_DETECT:     next_system_data = read_word;
        emc_pkg::EMC_MODE_NORMAL:     next_system_data = read_word;
        emc_pkg::EMC_MODE_INJECT:     next_system_data = read_word;
        default:                      next_system_data = read_word;
      endcase
    end
  end

  always_comb begin
    for (int b = 0; b < emc_pkg::EMC_BYTES; b++) begin
      next_parity[b] = ^next_system_data[8*b +: 8] ^ mode_reg.parity_odd;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      system_data_out <= '0;
      parity_out      <= '0;
    end else begin
      system_data_out <= next_system_data;
      parity_out      <= next_parity;
    end
  end

  assign system_data_oe = system_output_enable_n ? 8'h00 : byte_lane_enables;

  // ==========================================================================
  // memory write path with byte merge and wrap of the registered system output word
  assign wrap_path = !write_buffer_select && (&byte_lane_enables);

  always_comb begin
    for (int b = 0; b < emc_pkg::EMC_BYTES; b++) begin
      if (wrap_path) begin
        merged_word[8*b +: 8] = system_data_out[8*b +: 8];
      end else if (byte_lane_enables[b]) begin
        merged_word[8*b +: 8] = sd_latch[8*b +: 8];
      end else begin
        merged_word[8*b +: 8] = read_word[8*b +: 8];
      end
    end
  end

  emc_checkbit_gen u_write_gen (
    .data_word (merged_word),
    .checkbits (write_gen_cb)
  );

  always_comb begin
    for (int b = 0; b < emc_pkg::EMC_BYTES; b++) begin
      write_parity[b] = ^sd_latch[8*b +: 8] ^ mode_reg.parity_odd;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      memory_data_out <= '0;
      checkbit_output <= emc_pkg::EMC_ZERO_CHECKBITS;
      parity_error_n  <= 1'b1;
    end else if (memory_write_strobe) begin
      memory_data_out <= merged_word;
      checkbit_output <= write_gen_cb;
      // only system-sourced lanes are checked on a partial write
      parity_error_n  <= ((parity_in ^ write_parity) & byte_lane_enables) == 8'h00;
    end
  end

endmodule : emc_mode_control

// [emc_mode_control_checker.sv]
// concurrent checks on the mode control ports
`timescale 1ns/10ps
module emc_mode_control_checker (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        mode_write_enable_n,
  input wire logic [63:0] system_data_in,
  input wire logic [63:0] system_data_out,
  input wire logic [7:0]  system_data_oe,
  input wire logic        system_output_enable_n,
  input wire logic [7:0]  byte_lane_enables,
  input wire logic        memory_read_strobe,
  input wire logic        memory_write_strobe,
  input wire logic [63:0] memory_data_out,
  input wire logic [7:0]  checkbit_output,
  input wire logic        error_flag_n,
  input wire logic        multi_error_flag_n,
  input wire logic        fifo_depth_select,
  input wire logic [4:0]  fifo_depth,
  input wire logic [2:0]  edc_mode_field
);
  // ==========================================================================
  // one domain, reset disables every check
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // ==========================================================================
  // mode register and output enable
  AST_MODE_FIELD: assert property (!mode_write_enable_n |=> edc_mode_field == $past(system_data_in[2:0]))
    else $error("mode field not loaded");
  AST_FIFO_DEPTH: assert property (!mode_write_enable_n |=> fifo_depth_select == $past(system_data_in[4])
    && fifo_depth == (fifo_depth_select ? 5'h10 : 5'h08)) else $error("fifo depth wrong");
  AST_READBACK: assert property ((!mode_write_enable_n && system_data_in[6]) ##1 mode_write_enable_n
    |=> system_data_out == {48'h0, $past(system_data_in[15:0], 2) & 16'h007F}) else $error("readback wrong");
  // reads one cycle back may still land, so they are excluded
  AST_CLEAR_ZERO: assert property ((!memory_read_strobe)[*3] ##0 (!mode_write_enable_n && system_data_in[3]
    && system_data_in[2:0] == 3'h0 && !system_data_in[6]) ##1 mode_write_enable_n |=> system_data_out == 64'h0)
    else $error("error data not cleared");
  AST_OUT_ENABLE: assert property (system_data_oe == ({8{!system_output_enable_n}} & byte_lane_enables))
    else $error("output enable wrong");

  // ==========================================================================
  // read flags and write path
  AST_MULTI_IS_ERR: assert property (!multi_error_flag_n |-> !error_flag_n)
    else $error("multi flag without error flag");
  AST_FLAG_CAUSE: assert property ($changed(error_flag_n) || $changed(multi_error_flag_n)
    |-> $past(memory_read_strobe, 2) || $past(memory_read_strobe, 3)) else $error("flags moved without read");
  AST_WRITE_CAUSE: assert property ($changed(checkbit_output) || $changed(memory_data_out)
    |-> $past(memory_write_strobe)) else $error("write outputs moved without strobe");
  AST_ZERO_CODE: assert property (memory_data_out != 64'h0 || checkbit_output == 8'h0C)
    else $error("zero word code wrong");

  COV_READ_ERR: cover property (memory_read_strobe ##2 !error_flag_n);
  COV_INIT_WRITE: cover property (memory_write_strobe ##1 checkbit_output == 8'h0C);
  COV_READBACK: cover property (!mode_write_enable_n && system_data_in[6]);
endmodule : emc_mode_control_checker

// [emc_memory_model.sv]
// memory array model holding one word on the far side of the block
`timescale 1ns/10ps
module emc_memory_model (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        memory_write_strobe,
  input  wire logic [63:0] memory_data_out,
  input  wire logic [7:0]  checkbit_output,
  input  wire logic        read_drive,
  input  wire logic [63:0] flip_data,
  input  wire logic [7:0]  flip_check,
  output logic      [63:0] memory_data_in,
  output logic      [7:0]  checkbit_input
);
  // ==========================================================================
  // storage; written word is registered a cycle after the strobe
  logic        wr_d;
  logic [71:0] word;
  logic [71:0] last;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_d <= 1'b0;
      word <= 72'h0;
      last <= 72'h0;
    end else begin
      wr_d <= memory_write_strobe;
      if (wr_d) word <= {checkbit_output, memory_data_out};
      if (read_drive) last <= word ^ {flip_check, flip_data};
    end
  end

  // released bus shows the inverse so a late capture cannot pass
  assign {checkbit_input, memory_data_in} = read_drive ? word ^ {flip_check, flip_data} : ~last;
endmodule : emc_memory_model

// [edc_mode_control_test.sv]
// self-checking bench for the edc mode control block
`timescale 1ns/10ps
module edc_mode_control_test;
  // ==========================================================================
  // signals
  logic        clk_sys, reset_n, mode_write_enable_n, system_input_latch_enable, write_buffer_select;
  logic        memory_read_strobe, memory_write_strobe, read_drive, error_flag_n;
  logic        multi_error_flag_n, fifo_depth_select, parity_error_n;
  logic [63:0] system_data_in, system_data_out, memory_data_in, memory_data_out, flip_data;
  logic [7:0]  system_data_oe, byte_lane_enables, parity_out, checkbit_input, checkbit_output, flip_check;
  logic [4:0]  fifo_depth;
  logic [2:0]  edc_mode_field;
  int          err_count = 0;
  int          tests_run = 0;

  emc_mode_control uut (.clk_sys, .reset_n, .mode_write_enable_n, .system_data_in, .system_data_out,
    .system_data_oe, .system_output_enable_n(1'h0), .system_input_latch_enable, .byte_lane_enables,
    .write_buffer_select, .parity_in(8'h00), .parity_out, .parity_error_n, .memory_data_in,
    .checkbit_input, .memory_read_strobe, .memory_write_strobe, .memory_data_out, .checkbit_output,
    .error_flag_n, .multi_error_flag_n, .fifo_depth_select, .fifo_depth, .edc_mode_field);
  emc_memory_model u_mem (.clk_sys, .reset_n, .memory_write_strobe, .memory_data_out, .checkbit_output,
    .read_drive, .flip_data, .flip_check, .memory_data_in, .checkbit_input);

  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // tasks
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic set_mode(input logic [15:0] v);
    @(negedge clk_sys);
    mode_write_enable_n = 1'h0;
    system_data_in = {48'h0, v};
    @(negedge clk_sys);
    mode_write_enable_n = 1'h1;
    @(negedge clk_sys);
  endtask : set_mode

  // flips come from the memory side; flags checked once the result stands
  task automatic rd(input logic [63:0] fd, input logic [7:0] fc, input logic [1:0] flags);
    @(negedge clk_sys);
    flip_data = fd;
    flip_check = fc;
    read_drive = 1'h1;
    memory_read_strobe = 1'h1;
    @(negedge clk_sys);
    memory_read_strobe = 1'h0;
    read_drive = 1'h0;
    repeat (3) @(negedge clk_sys);
    chk("flags", {62'h0, flags}, {62'h0, error_flag_n, multi_error_flag_n});
  endtask : rd

  task automatic latch_in(input logic [63:0] v);
    @(negedge clk_sys);
    system_data_in = v;
    system_input_latch_enable = 1'h1;
    @(negedge clk_sys);
    system_input_latch_enable = 1'h0;
  endtask : latch_in

  task automatic wr_mem(input logic [7:0] lanes, input logic [63:0] v);
    byte_lane_enables = lanes;
    latch_in(v);
    memory_write_strobe = 1'h1;
    @(negedge clk_sys);
    memory_write_strobe = 1'h0;
    @(negedge clk_sys);
  endtask : wr_mem

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (3000) @(posedge clk_sys);
    err_count++;
    $display("timeout");
    end_sim();
  end

  // ==========================================================================
  // tests
  initial begin
    emc_pkg::emc_diag_t d;
    logic [7:0] inj [3];
    logic [1:0] flg [3];
    inj = '{8'h0B, 8'h0A, 8'h08};
    flg = '{2'b11, 2'b01, 2'b00};
    reset_n = 1'h0;
    mode_write_enable_n = 1'h1;
    system_data_in = 64'h0;
    system_input_latch_enable = 1'h0;
    byte_lane_enables = 8'hFF;
    write_buffer_select = 1'h0;
    memory_read_strobe = 1'h0;
    memory_write_strobe = 1'h0;
    read_drive = 1'h0;
    flip_data = 64'h0;
    flip_check = 8'h00;
    repeat (3) @(negedge clk_sys);
    chk("reset code", 8'h0C, checkbit_output);
    chk("reset depth", 5'h08, fifo_depth);
    reset_n = 1'h1;
    $display("test reset done");
    set_mode(16'hFF52);
    chk("field", 3'h2, edc_mode_field);
    chk("depth", 5'h10, fifo_depth);
    chk("readback", 64'h52, system_data_out);
    set_mode(16'h0003);
    chk("no readback", 64'h0, system_data_out);
    $display("test mode register done");
    set_mode(16'h0043);
    chk("even parity", 8'h01, parity_out);
    set_mode(16'h0063);
    chk("odd parity", 8'hFF, parity_out);
    $display("test parity done");
    // wrap path must win over the all-ones input latch
    set_mode(16'h0008);
    chk("cleared", 64'h0, system_data_out);
    wr_mem(8'hFF, {64{1'h1}});
    chk("init data", 64'h0, memory_data_out);
    chk("init code", 8'h0C, checkbit_output);
    $display("test init done");
    set_mode(16'h0003);
    rd(64'h1, 8'h00, 2'b01);
    chk("corrected", 64'h0, system_data_out);
    rd(64'h0, 8'h03, 2'b00);
    set_mode(16'h0001);
    d = '{8'h03, 1'h0, 1'h1, 4'h2, 8'h07, 8'h0C, 8'h0F};
    chk("diag", {26'h0, d}, system_data_out);
    set_mode(16'h0000);
    chk("error data", 64'h1, system_data_out);
    $display("test errors done");
    set_mode(16'h0002);
    rd(64'h1, 8'h00, 2'b01);
    chk("raw", 64'h1, system_data_out);
    $display("test detect done");
    set_mode(16'h0003);
    rd(64'h0, 8'h00, 2'b11);
    wr_mem(8'h01, 64'h1);
    chk("merge", 64'h1, memory_data_out);
    chk("gen code", 8'h0B, checkbit_output);
    chk("parity error", 64'h0, parity_error_n);
    rd(64'h0, 8'h00, 2'b11);
    chk("round trip", 64'h1, system_data_out);
    $display("test write done");
    set_mode(16'h0004);
    for (int i = 0; i < 3; i++) begin
      latch_in({56'h0, inj[i]});
      rd(64'h0, 8'h00, flg[i]);
    end
    $display("test inject done");
    set_mode(16'h0008);
    chk("clear again", 64'h0, system_data_out);
    // buffer select high breaks the wrap, so the input latch goes out
    write_buffer_select = 1'h1;
    wr_mem(8'hFF, 64'h2);
    chk("no wrap", 64'h2, memory_data_out);
    chk("parity error lanes", 64'h0, parity_error_n);
    write_buffer_select = 1'h0;
    wr_mem(8'hFF, {64{1'h1}});
    chk("reinit data", 64'h0, memory_data_out);
    chk("reinit code", 8'h0C, checkbit_output);
    chk("parity ok", 64'h1, parity_error_n);
    $display("test clear done");
    end_sim();
  end
endmodule : edc_mode_control_test

bind emc_mode_control emc_mode_control_checker u_chk (.clk_sys, .reset_n, .mode_write_enable_n, .system_data_in,
  .system_data_out, .system_data_oe, .system_output_enable_n, .byte_lane_enables, .memory_read_strobe,
  .memory_write_strobe, .memory_data_out, .checkbit_output, .error_flag_n, .multi_error_flag_n,
  .fifo_depth_select, .fifo_depth, .edc_mode_field);
